// >>> src/pbd_pkg.sv
`default_nettype none
package pbd_pkg;

  // pixel path widths
  localparam int unsigned PIX_W = 12;
  localparam int unsigned ACC_W = 16;   // 16 cells of full-scale 12-bit data fit
  localparam int unsigned FAC_W = 3;
  localparam int unsigned COL_W = 10;
  localparam int unsigned MAX_COLS = 1024;
  localparam logic [PIX_W-1:0] PIX_MAX = 12'h0fff;
  localparam logic [FAC_W-1:0] FAC_ONE = 3'h1;
  localparam logic [FAC_W-1:0] FAC_MAX = 3'h4;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_COMBINE = 8'h04;
  localparam logic [7:0] OFS_SKIP    = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0c;

  // control register fields
  localparam int unsigned CTRL_STREAM     = 0;
  localparam int unsigned CTRL_DIG_OFF    = 1;  // request to switch the digital processor off
  localparam int unsigned CTRL_COLOR_FMT  = 2;  // output format needs colour interpolation
  localparam int unsigned CTRL_SENS_NOAVG = 3;  // sensor cannot average
  localparam int unsigned CTRL_SENS_NOCMB = 4;  // sensor cannot combine or would degrade image

  // combine and skip register fields (same layout)
  localparam int unsigned FLD_ENG_LO  = 0;
  localparam int unsigned FLD_HALG    = 2;
  localparam int unsigned FLD_VALG    = 3;
  localparam int unsigned FLD_HFAC_LO = 4;
  localparam int unsigned FLD_VFAC_LO = 8;

  // status register fields
  localparam int unsigned ST_STREAM   = 0;
  localparam int unsigned ST_COMB_ACT = 1;
  localparam int unsigned ST_SKIP_ACT = 2;
  localparam int unsigned ST_DIG_EN   = 3;
  localparam int unsigned ST_COMB_SEN = 4;
  localparam int unsigned ST_ERR_WR   = 8;
  localparam int unsigned ST_ERR_DIG  = 9;

  typedef enum logic [1:0] {
    ENG_ALL,
    ENG_SENSOR,
    ENG_DIGITAL
  } pbd_engine_t;

  // reset values: combining on the sensor engine, additive, no reduction
  localparam logic [15:0] CTRL_RST    = 16'h0000;
  localparam logic [15:0] COMBINE_RST = 16'h0111;
  localparam logic [15:0] SKIP_RST    = 16'h0110;

endpackage
`default_nettype wire

// >>> src/pbd_reduce.sv
`default_nettype none
module pbd_reduce
  import pbd_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             inValid,
  input  wire logic [PIX_W-1:0] inData,
  input  wire logic             inSof,
  input  wire logic             inEol,
  input  wire logic [FAC_W-1:0] facH,
  input  wire logic [FAC_W-1:0] facV,
  input  wire logic             avgH,
  input  wire logic             avgV,
  input  wire logic             skip,
  output logic                  outValid,
  output logic [PIX_W-1:0]      outData,
  output logic                  outSof,
  output logic                  outEol
);

  logic [ACC_W-1:0] lineBuf [MAX_COLS];
  logic [FAC_W-1:0] hCnt_q, hCnt_d, vCnt_q, vCnt_d, hPos, vPos;
  logic [COL_W-1:0] col_q, col_d, colPos;
  logic [ACC_W-1:0] hAcc_q, hAcc_d, colVal, quot;
  logic [5:0]       divisor;
  logic             pendSof_q, pendSof_d, hLast, vLast, emit;
  logic             outValid_d, outSof_d, outEol_d;
  logic [PIX_W-1:0] outData_d;

  // window position; a frame start restarts every window
  always_comb begin
    hPos    = inSof ? '0 : hCnt_q;
    vPos    = inSof ? '0 : vCnt_q;
    colPos  = inSof ? '0 : col_q;
    hLast   = (hPos == facH - FAC_ONE) || inEol;
    vLast   = (vPos == facV - FAC_ONE);
    emit    = inValid && hLast && vLast;
    divisor = 6'((avgH ? facH : FAC_ONE) * (avgV ? facV : FAC_ONE));
    // [R9] discard keeps first pixel
    if (hPos == '0) begin
      hAcc_d = ACC_W'(inData);
    end else if (skip) begin
      hAcc_d = hAcc_q;
    end else begin
      hAcc_d = hAcc_q + ACC_W'(inData);
    end
    // [R10] one of N lines kept
    if (vPos == '0) begin
      colVal = hAcc_d;
    end else if (skip) begin
      colVal = lineBuf[colPos];
    end else begin
      colVal = lineBuf[colPos] + hAcc_d;
    end
    // [R17] truncating divide of full sum
    quot = colVal / ACC_W'(divisor);
    hCnt_d     = hCnt_q;
    vCnt_d     = vCnt_q;
    col_d      = col_q;
    pendSof_d  = pendSof_q | (inValid & inSof);
    outValid_d = emit;
    outSof_d   = emit & (pendSof_q | inSof);
    outEol_d   = emit & inEol;
    outData_d  = outData;
    if (inValid) begin
      hCnt_d = hLast ? '0 : hPos + FAC_ONE;
      col_d  = inEol ? '0 : (hLast ? colPos + 1'b1 : colPos);
      vCnt_d = inEol ? (vLast ? '0 : vPos + FAC_ONE) : vPos;
    end else begin
      hAcc_d = hAcc_q;  // idle cycles keep the partial sum
    end
    if (emit) begin
      pendSof_d = 1'b0;
      // [R4] sum saturates at full scale
      if (skip) begin
        outData_d = colVal[PIX_W-1:0];
      end else if (quot > ACC_W'(PIX_MAX)) begin
        outData_d = PIX_MAX;
      end else begin
        // [R5] mean of combined cells
        outData_d = quot[PIX_W-1:0];
      end
    end
  end

  // window sums of the current group row; no reset needed on data storage
  always_ff @(posedge clk) begin
    if (inValid && hLast) begin
      lineBuf[colPos] <= colVal;
    end
  end

  // counters, partial sum and output stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hCnt_q    <= '0;
      vCnt_q    <= '0;
      col_q     <= '0;
      hAcc_q    <= '0;
      pendSof_q <= 1'b0;
      outValid  <= 1'b0;
      outData   <= '0;
      outSof    <= 1'b0;
      outEol    <= 1'b0;
    end else begin
      hCnt_q    <= hCnt_d;
      vCnt_q    <= vCnt_d;
      col_q     <= col_d;
      hAcc_q    <= hAcc_d;
      pendSof_q <= pendSof_d;
      outValid  <= outValid_d;
      outData   <= outData_d;
      outSof    <= outSof_d;
      outEol    <= outEol_d;
    end
  end

endmodule // pbd_reduce
`default_nettype wire

// >>> src/pbd_top.sv
// Operation
// [R1] combining and skipping never active together
// [R2] settings frozen while streaming is on
// [R3] engine choice covers both axes jointly
// [R4] additive mode outputs sum of cells
// [R5] averaging mode outputs mean of cells
// [R6] factor divides resolution; one means none
// [R7] skipping only when combine factors are one
// [R8] skipping never done by digital processor
// [R9] discard is the only skip algorithm
// [R10] keep one pixel per window of N
// [R11] combining only when skip factors are one
// [R12] combining defaults to the sensor engine
// [R13] digital processor combines when sensor cannot
// [R14] processor off means sensor does all combining
// [R15] colour formats refuse processor switch-off
// [R16] total engine picks best split itself
// [R17] average truncated, sum saturated to pixel width
`default_nettype none
module pbd_top
  import pbd_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [7:0]       adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [31:0]      dat_i,
  output logic [31:0]           dat_o,
  output logic                  ack_o,
  input  wire logic             sensPixValid,
  input  wire logic [PIX_W-1:0] sensPixData,
  input  wire logic             sensPixSof,
  input  wire logic             sensPixEol,
  output logic                  fmtPixValid,
  output logic [PIX_W-1:0]      fmtPixData,
  output logic                  fmtPixSof,
  output logic                  fmtPixEol
);

  logic [15:0]      ctrl_q, ctrl_d, comb_q, comb_d, skip_q, skip_d;
  logic             errWr_q, errWr_d, errDig_q, errDig_d;
  logic             ack_d;
  logic [31:0]      dat_d;
  logic [15:0]      wrMask, newCtrl, newComb, newSkip, status;
  logic             wrCycle, streaming, badComb, badSkip, setErrWr, setErrDig;
  logic [FAC_W-1:0] combH, combV, skipH, skipV;
  logic             avgH, avgV, digEn, sensorOk, combActive, skipActive, combOnSensor;
  pbd_engine_t      combEng;
  logic [FAC_W-1:0] senFacH, senFacV, digFacH, digFacV;
  logic             midValid, midSof, midEol;
  logic [PIX_W-1:0] midData;

  // field views of the held settings
  always_comb begin
    combEng   = pbd_engine_t'(comb_q[FLD_ENG_LO +: 2]);
    avgH      = comb_q[FLD_HALG];
    avgV      = comb_q[FLD_VALG];
    combH     = comb_q[FLD_HFAC_LO +: FAC_W];
    combV     = comb_q[FLD_VFAC_LO +: FAC_W];
    skipH     = skip_q[FLD_HFAC_LO +: FAC_W];
    skipV     = skip_q[FLD_VFAC_LO +: FAC_W];
    streaming = ctrl_q[CTRL_STREAM];
    digEn     = ~ctrl_q[CTRL_DIG_OFF];
  end

  // engine routing; the sensor is preferred because it keeps the frame rate up
  always_comb begin
    sensorOk = ~ctrl_q[CTRL_SENS_NOCMB] & ~((avgH | avgV) & ctrl_q[CTRL_SENS_NOAVG]);
    // [R14] processor off forces sensor
    if (!digEn) begin
      combOnSensor = 1'b1;
    end else begin
      case (combEng)
        // [R12] sensor engine by default
        ENG_SENSOR:  combOnSensor = sensorOk;
        // [R16] total engine chooses split
        ENG_ALL:     combOnSensor = sensorOk;
        // [R13] processor does the combining
        ENG_DIGITAL: combOnSensor = 1'b0;
        default:     combOnSensor = sensorOk;
      endcase
    end
    // [R1] exclusive through opposite unit checks
    // [R11] combining needs unit skip
    combActive = (skipH == FAC_ONE) && (skipV == FAC_ONE) && ((combH != FAC_ONE) || (combV != FAC_ONE));
    // [R7] skipping needs unit combine
    skipActive = (combH == FAC_ONE) && (combV == FAC_ONE) && ((skipH != FAC_ONE) || (skipV != FAC_ONE));
  end

  // per-stage factors; both axes always follow one engine choice
  always_comb begin
    senFacH = FAC_ONE;
    senFacV = FAC_ONE;
    digFacH = FAC_ONE;
    digFacV = FAC_ONE;
    // [R3] both axes on one engine
    if (combActive && combOnSensor) begin
      senFacH = combH;
      senFacV = combV;
    end else if (combActive) begin
      digFacH = combH;
      digFacV = combV;
    end
    // [R8] skipping only on sensor stage
    if (skipActive) begin
      senFacH = skipH;
      senFacV = skipV;
    end
  end

  // bus write staging: byte lanes merge into the held value before checking
  always_comb begin
    wrMask  = {{8{sel_i[1]}}, {8{sel_i[0]}}};
    wrCycle = cyc_i & stb_i & we_i & ~ack_o;
    newCtrl = (dat_i[15:0] & wrMask) | (ctrl_q & ~wrMask);
    newComb = (dat_i[15:0] & wrMask) | (comb_q & ~wrMask);
    newSkip = (dat_i[15:0] & wrMask) | (skip_q & ~wrMask);
    newSkip[FLD_HALG] = 1'b0;  // discard encoded as zero, nothing else exists
    newSkip[FLD_VALG] = 1'b0;
    badComb = (newComb[FLD_ENG_LO +: 2] > 2'(ENG_DIGITAL))
            || (newComb[FLD_HFAC_LO +: FAC_W] == '0) || (newComb[FLD_HFAC_LO +: FAC_W] > FAC_MAX)
            || (newComb[FLD_VFAC_LO +: FAC_W] == '0) || (newComb[FLD_VFAC_LO +: FAC_W] > FAC_MAX);
    badSkip = (newSkip[FLD_ENG_LO +: 2] > 2'(ENG_SENSOR))
            || (newSkip[FLD_HFAC_LO +: FAC_W] == '0) || (newSkip[FLD_HFAC_LO +: FAC_W] > FAC_MAX)
            || (newSkip[FLD_VFAC_LO +: FAC_W] == '0) || (newSkip[FLD_VFAC_LO +: FAC_W] > FAC_MAX);
  end

  // register updates and refusal flags
  always_comb begin
    ctrl_d    = ctrl_q;
    comb_d    = comb_q;
    skip_d    = skip_q;
    setErrWr  = 1'b0;
    setErrDig = 1'b0;
    if (wrCycle) begin
      case (adr_i)
        OFS_CTRL: begin
          // [R2] only the stream bit moves mid-stream
          if (streaming) begin
            ctrl_d[CTRL_STREAM] = newCtrl[CTRL_STREAM];
            setErrWr = (newCtrl[4:1] != ctrl_q[4:1]);
          end else begin
            ctrl_d = {11'h000, newCtrl[4:0]};
            // [R15] colour formats keep processor on
            if (newCtrl[CTRL_DIG_OFF] && newCtrl[CTRL_COLOR_FMT]) begin
              ctrl_d[CTRL_DIG_OFF] = 1'b0;
              setErrDig = 1'b1;
            end
          end
        end
        OFS_COMBINE: begin
          // [R2] combine settings frozen while streaming
          if (streaming || badComb) begin
            setErrWr = 1'b1;
          end else begin
            comb_d = {5'h00, newComb[10:8], 1'b0, newComb[6:4], newComb[3:0]};
          end
        end
        OFS_SKIP: begin
          // [R8] digital engine refused for skipping
          if (streaming || badSkip) begin
            setErrWr = 1'b1;
          end else begin
            skip_d = {5'h00, newSkip[10:8], 1'b0, newSkip[6:4], newSkip[3:0]};
          end
        end
        default: ;
      endcase
    end
    // sticky errors: writing one clears, a new refusal in that cycle wins
    errWr_d  = errWr_q;
    errDig_d = errDig_q;
    if (wrCycle && adr_i == OFS_STATUS) begin
      errWr_d  = errWr_q & ~(dat_i[ST_ERR_WR] & sel_i[1]);
      errDig_d = errDig_q & ~(dat_i[ST_ERR_DIG] & sel_i[1]);
    end
    errWr_d  = errWr_d | setErrWr;
    errDig_d = errDig_d | setErrDig;
  end

  // read mux; ack follows one cycle after the request, unmapped reads give zero
  always_comb begin
    status                 = '0;
    status[ST_STREAM]      = streaming;
    status[ST_COMB_ACT]    = combActive;
    status[ST_SKIP_ACT]    = skipActive;
    status[ST_DIG_EN]      = digEn;
    status[ST_COMB_SEN]    = combOnSensor;
    status[ST_ERR_WR]      = errWr_q;
    status[ST_ERR_DIG]     = errDig_q;
    ack_d = cyc_i & stb_i & ~ack_o;
    dat_d = dat_o;
    if (ack_d) begin
      case (adr_i)
        OFS_CTRL:    dat_d = {16'h0000, ctrl_q};
        OFS_COMBINE: dat_d = {16'h0000, comb_q};
        OFS_SKIP:    dat_d = {16'h0000, skip_q};
        OFS_STATUS:  dat_d = {16'h0000, status};
        default:     dat_d = 32'h0000_0000;
      endcase
    end
  end

  // register bank and bus answer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q   <= CTRL_RST;
      comb_q   <= COMBINE_RST;
      skip_q   <= SKIP_RST;
      errWr_q  <= 1'b0;
      errDig_q <= 1'b0;
      ack_o    <= 1'b0;
      dat_o    <= 32'h0000_0000;
    end else begin
      ctrl_q   <= ctrl_d;
      comb_q   <= comb_d;
      skip_q   <= skip_d;
      errWr_q  <= errWr_d;
      errDig_q <= errDig_d;
      ack_o    <= ack_d;
      dat_o    <= dat_d;
    end
  end

  // [R6] sensor-side stage reduces first
  pbd_reduce u_sensor_stage (
    .clk      (clk),
    .rstn     (rstn),
    .inValid  (sensPixValid & streaming),
    .inData   (sensPixData),
    .inSof    (sensPixSof),
    .inEol    (sensPixEol),
    .facH     (senFacH),
    .facV     (senFacV),
    .avgH     (avgH),
    .avgV     (avgV),
    .skip     (skipActive),
    .outValid (midValid),
    .outData  (midData),
    .outSof   (midSof),
    .outEol   (midEol)
  );

  // digital stage only ever combines, never skips
  pbd_reduce u_digital_stage (
    .clk      (clk),
    .rstn     (rstn),
    .inValid  (midValid),
    .inData   (midData),
    .inSof    (midSof),
    .inEol    (midEol),
    .facH     (digFacH),
    .facV     (digFacV),
    .avgH     (avgH),
    .avgV     (avgV),
    .skip     (1'b0),
    .outValid (fmtPixValid),
    .outData  (fmtPixData),
    .outSof   (fmtPixSof),
    .outEol   (fmtPixEol)
  );

  // checks on the routing and the register guard
  a_never_both_active: assert property (@(posedge clk) disable iff (!rstn) // [R1]
    !(combActive && skipActive)) else $error("combining and skipping both active");

  a_frozen_in_stream: assert property (@(posedge clk) disable iff (!rstn) // [R2]
    streaming && $past(streaming) |-> $stable(comb_q) && $stable(skip_q))
    else $error("settings changed while streaming");

  a_axes_joint_engine: assert property (@(posedge clk) disable iff (!rstn) // [R3]
    combActive |-> (combOnSensor ? (senFacH == combH && senFacV == combV && digFacH == FAC_ONE)
                                 : (digFacH == combH && digFacV == combV && senFacH == FAC_ONE)))
    else $error("axes split across engines");

  a_skip_needs_unit: assert property (@(posedge clk) disable iff (!rstn) // [R7]
    (combH != FAC_ONE) |-> !skipActive && (senFacH == FAC_ONE || combOnSensor))
    else $error("skipping active with combine factor");

  a_digital_no_skip: assert property (@(posedge clk) disable iff (!rstn) // [R8]
    skipActive |-> digFacH == FAC_ONE && digFacV == FAC_ONE && senFacH == skipH)
    else $error("digital stage handles skipping");

  a_comb_needs_unit: assert property (@(posedge clk) disable iff (!rstn) // [R11]
    (skipV != FAC_ONE) |-> !combActive) else $error("combining active with skip factor");

  a_sensor_default: assert property (@(posedge clk) disable iff (!rstn) // [R12]
    combActive && digEn && sensorOk && combEng != ENG_DIGITAL |-> senFacV == combV)
    else $error("supported sensor not used for combining");

  a_digital_fallback: assert property (@(posedge clk) disable iff (!rstn) // [R13]
    combActive && digEn && !sensorOk |-> digFacH == combH && digFacV == combV)
    else $error("processor did not take over combining");

  a_off_means_sensor: assert property (@(posedge clk) disable iff (!rstn) // [R14]
    !digEn |-> digFacH == FAC_ONE && digFacV == FAC_ONE) else $error("processor combines while off");

  a_colour_keeps_on: assert property (@(posedge clk) disable iff (!rstn) // [R15]
    wrCycle && !streaming && adr_i == OFS_CTRL && newCtrl[CTRL_DIG_OFF] && newCtrl[CTRL_COLOR_FMT]
    |=> digEn && errDig_q) else $error("processor switched off under colour format");

  a_bus_single_ack: assert property (@(posedge clk) disable iff (!rstn)
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o) else $error("ack not a single pulse");

endmodule // pbd_top
`default_nettype wire

// >>> bench/pbd_sensor_model.sv
`default_nettype none
module pbd_sensor_model
  import pbd_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             go,
  input  wire logic             slow,
  input  wire logic [3:0]       w,
  input  wire logic [3:0]       h,
  input  var  logic [PIX_W-1:0] img [128],
  output logic                  busy,
  output logic                  valid,
  output logic [PIX_W-1:0]      data,
  output logic                  sof,
  output logic                  eol
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] x;
  logic [3:0] y;

  // raster readout of one frame; slow mode drops valid on random cycles
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy  <= 1'b0;
      valid <= 1'b0;
      sof   <= 1'b0;
      eol   <= 1'b0;
      data  <= '0;
      x     <= '0;
      y     <= '0;
    end else begin
      // idle data line toggles so a stale pixel is never mistaken for a fresh one
      valid <= 1'b0;
      sof   <= 1'b0;
      eol   <= 1'b0;
      data  <= ~data;
      if (!busy) begin
        if (go) begin
          busy <= 1'b1;
          x    <= '0;
          y    <= '0;
        end
      end else if (!(slow && ($urandom % 2 == 0))) begin
        valid <= 1'b1;
        data  <= img[int'(y) * int'(w) + int'(x)];
        sof   <= (x == 0) && (y == 0);
        eol   <= (x == w - 1);
        if (x == w - 1) begin
          x <= '0;
          y <= y + 4'h1;
          if (y == h - 1) busy <= 1'b0;
        end else begin
          x <= x + 4'h1;
        end
      end
    end
  end
endmodule // pbd_sensor_model
`default_nettype wire

// >>> bench/tb_pbd_top.sv
`default_nettype none
module tb_pbd_top;
  import pbd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [15:0] CFG_REG [8] = '{16'h0111, 16'h0221, 16'h022e, 16'h0144,
                                          16'h0339, 16'h0221, 16'h0340, 16'h0411};
  localparam logic [4:0]  CFG_CTL [8] = '{5'h00, 5'h10, 5'h00, 5'h08, 5'h12, 5'h00, 5'h00, 5'h00};
  localparam logic [7:0]  CFG_SKIP    = 8'he0;

  logic             clk = 1'b0;
  logic             rstn = 1'b0;
  logic             cyc = 1'b0;
  logic             stb = 1'b0;
  logic             we = 1'b0;
  logic [7:0]       adr = '0;
  logic [3:0]       sel = '0;
  logic [31:0]      datW = '0;
  logic [31:0]      datR;
  logic             ack;
  logic             go = 1'b0;
  logic             slow = 1'b0;
  logic             busy;
  logic             sValid;
  logic [PIX_W-1:0] sData;
  logic             sSof;
  logic             sEol;
  logic             fValid;
  logic [PIX_W-1:0] fData;
  logic             fSof;
  logic             fEol;
  logic [3:0]       frameW = 4'h1;
  logic [3:0]       frameH = 4'h1;
  logic [PIX_W-1:0] img [128];
  logic [13:0]      outQ [$];
  logic [13:0]      expQ [$];
  logic [15:0]      cReg;
  logic [4:0]       ctl;
  logic [2:0]       fh;
  logic [2:0]       fv;
  logic             sk;
  logic             ah;
  logic             av;
  logic             act;
  logic [31:0]      rd;
  int               err_total = 0;
  int               tests_run = 0;
  int               cycles = 0;

  always #10 clk = ~clk;

  pbd_top uut (
    .clk(clk), .rstn(rstn), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(datW), .dat_o(datR), .ack_o(ack), .sensPixValid(sValid), .sensPixData(sData),
    .sensPixSof(sSof), .sensPixEol(sEol), .fmtPixValid(fValid), .fmtPixData(fData),
    .fmtPixSof(fSof), .fmtPixEol(fEol)
  );

  pbd_sensor_model sensor (
    .clk(clk), .rstn(rstn), .go(go), .slow(slow), .w(frameW), .h(frameH), .img(img),
    .busy(busy), .valid(sValid), .data(sData), .sof(sSof), .eol(sEol)
  );

  // formatter side never stalls, so every output pixel is captured
  always @(posedge clk) begin
    if (fValid === 1'b1) outQ.push_back({fSof, fEol, fData});
  end

  // hang guard: generous against eight short frames
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // classic single cycle; waits for ack, the global guard bounds the wait
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= wr;
    adr  <= a;
    datW <= d;
    sel  <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    q = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  // expected stream: one output per window, sum or mean, or first cell when skipping
  function automatic void build_exp();
    logic [31:0] s;
    int          dv;
    expQ.delete();
    dv = (ah ? int'(fh) : 1) * (av ? int'(fv) : 1);
    for (int gy = 0; gy < frameH / fv; gy++) begin
      for (int gx = 0; gx < frameW / fh; gx++) begin
        s = 0;
        for (int i = 0; i < fv; i++) begin
          for (int j = 0; j < fh; j++) begin
            if (!sk || (i == 0 && j == 0)) s += img[(gy * fv + i) * frameW + gx * fh + j];
          end
        end
        s = sk ? s : s / dv;
        if (s > PIX_MAX) s = PIX_MAX;
        expQ.push_back({gx == 0 && gy == 0, gx == frameW / fh - 1, s[PIX_W-1:0]});
      end
    end
  endfunction

  // expected routing: sensor stage unless the processor is on and either the digital engine is asked or the sensor cannot do the asked mode
  function automatic logic exp_route(input logic [4:0] cc, input logic [15:0] rr);
    return cc[CTRL_DIG_OFF] | (rr[1:0] != 2'(ENG_DIGITAL) && !cc[CTRL_SENS_NOCMB]
                               && !(cc[CTRL_SENS_NOAVG] && (rr[2] || rr[3])));
  endfunction

  // one frame of random size (whole windows) and content; fill forces full-scale cells
  task automatic run_frame(input logic fill);
    frameW = 4'(int'(fh) * (1 + $urandom % 3));
    frameH = 4'(int'(fv) * (1 + $urandom % 2));
    for (int i = 0; i < 128; i++) img[i] = fill ? PIX_MAX : PIX_W'($urandom);
    slow = 1'($urandom % 2);
    outQ.delete();
    build_exp();
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do @(posedge clk); while (busy === 1'b1);
    for (int k = 0; k < 20 && outQ.size() < expQ.size(); k++) @(posedge clk);
  endtask

  initial begin
    void'($urandom(26));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    // register reset values and an unmapped hole
    wb(1'b0, OFS_CTRL, '0, rd);
    check(rd, CTRL_RST, "ctrl reset");
    wb(1'b0, OFS_COMBINE, '0, rd);
    check(rd, COMBINE_RST, "combine reset");
    wb(1'b0, OFS_SKIP, '0, rd);
    check(rd, SKIP_RST, "skip reset");
    wb(1'b0, 8'h10, '0, rd);
    check(rd, 32'h0000_0000, "unmapped read");
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      cReg = CFG_REG[c];
      ctl  = CFG_CTL[c];
      sk   = CFG_SKIP[c];
      fh   = cReg[6:4];
      fv   = cReg[10:8];
      ah   = !sk && cReg[2];
      av   = !sk && cReg[3];
      act  = (fh != 1) || (fv != 1);
      // streaming is stopped before any setting changes
      wb(1'b1, OFS_CTRL, {27'h0, ctl}, rd);
      wb(1'b1, OFS_COMBINE, sk ? COMBINE_RST : cReg, rd);
      wb(1'b1, OFS_SKIP, sk ? cReg : SKIP_RST, rd);
      wb(1'b0, OFS_STATUS, '0, rd);
      check(rd[ST_COMB_ACT], !sk && act, "combine active");
      check(rd[ST_SKIP_ACT], sk && act, "skip active");
      check(rd[ST_DIG_EN], !ctl[CTRL_DIG_OFF], "processor on");
      if (!sk && act) check(rd[ST_COMB_SEN], exp_route(ctl, cReg), "route");
      wb(1'b0, sk ? OFS_SKIP : OFS_COMBINE, '0, rd);
      check(rd, cReg, "settings readback");
      wb(1'b1, OFS_CTRL, {27'h0, ctl} | 32'h0000_0001, rd);
      run_frame(c == 1);
      check(outQ.size(), expQ.size(), "output pixel count");
      foreach (expQ[i]) if (i < outQ.size()) check(outQ[i], expQ[i], "output pixel");
      // a control write mid-stream only moves the stream bit, so stop with unchanged settings first
      if (c < 7) wb(1'b1, OFS_CTRL, {27'h0, ctl}, rd);
      $display("test frame %0d done", c);
    end
    // still streaming: a settings write must be dropped and flagged
    wb(1'b1, OFS_COMBINE, 32'h0000_0221, rd);
    wb(1'b0, OFS_COMBINE, '0, rd);
    check(rd, COMBINE_RST, "frozen combine");
    wb(1'b0, OFS_STATUS, '0, rd);
    check(rd[ST_ERR_WR], 1'b1, "refusal flag");
    wb(1'b1, OFS_STATUS, 32'h0000_0300, rd);
    wb(1'b0, OFS_STATUS, '0, rd);
    check(rd[9:8], 2'h0, "flags cleared");
    // colour format forbids switching the processor off
    wb(1'b1, OFS_CTRL, 32'h0000_0000, rd);
    wb(1'b1, OFS_CTRL, 32'h0000_0006, rd);
    wb(1'b0, OFS_CTRL, '0, rd);
    check(rd, 32'h0000_0004, "processor kept on");
    wb(1'b0, OFS_STATUS, '0, rd);
    check(rd[ST_ERR_DIG], 1'b1, "processor refusal flag");
    // skipping on the digital engine is refused; discard is the only mode
    wb(1'b1, OFS_SKIP, 32'h0000_0112, rd);
    wb(1'b0, OFS_SKIP, '0, rd);
    check(rd, 32'h0000_0411, "skip engine refused");
    wb(1'b1, OFS_SKIP, 32'h0000_021d, rd);
    wb(1'b0, OFS_SKIP, '0, rd);
    check(rd[3:2], 2'h0, "discard only");
    // both reductions requested: neither may be active
    wb(1'b1, OFS_COMBINE, 32'h0000_0221, rd);
    wb(1'b1, OFS_SKIP, 32'h0000_0221, rd);
    wb(1'b0, OFS_STATUS, '0, rd);
    check(rd[2:1], 2'h0, "exclusive reductions");
    $display("test refusals done");
    report_and_stop();
  end
endmodule // tb_pbd_top
`default_nettype wire
